// [hw/swss_core.sv]
// Purpose: Slave-side bit signaling engine for a single-wire open-drain bus
// Assumes: Master originates every slot; line pin synchronised here
// Notes: Byte and command layers sit outside and feed tx_bit and overdrive set
`timescale 1ns/1ps
module swss_core
    import swss_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus line, open-drain
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    // Command layer
    input wire logic tx_bit,
    input wire logic fast_speed_set,
    output swss_rx_t rx,
    output swss_evt_t evt,
    output logic fast_speed_flag
);

    // ************************************************************
    // Line synchroniser
    // ************************************************************
    logic sync1_r;
    logic sync2_r;

    // Two stages; only the second is read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= line_in;
            sync2_r <= sync1_r;
        end
    end

    wire logic line_low = !sync2_r;

    // ************************************************************
    // State machine
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,   // Waiting for a slot or reset
        ST_SLOT = 6'h02,   // Slot timer running
        ST_WAITH = 6'h04,  // Waiting for line to go high
        ST_REH = 6'h08,    // Rising-edge hold-off
        ST_PDH = 6'h10,    // Presence delay
        ST_PDL = 6'h20     // Presence pulse driven
    } swss_state_t;

    swss_state_t state_r;
    swss_state_t state_nxt;
    logic fast_r;
    logic fast_nxt;
    logic [CNT_W-1:0] tmr_r;
    logic [CNT_W-1:0] tmr_nxt;
    logic drive_r;
    logic drive_nxt;
    logic bit_r;
    logic rx_valid_r;
    logic rx_valid_nxt;
    logic rx_data_r;
    logic rx_data_nxt;
    logic rst_pulse_r;
    logic rst_pulse_nxt;
    logic pres_done_r;
    logic pres_done_nxt;
    logic slot_pulse_r;
    logic slot_pulse_nxt;

    // ************************************************************
    // Line measurement
    // ************************************************************
    logic [CNT_W-1:0] low_cnt;
    logic [FILT_W-1:0] filt_cnt;

    // Length of the current low, for reset detection
    swss_lowcnt #(.W(CNT_W)) u_low (
        .clk(clk),
        .reset_n(reset_n),
        .cond(line_low),
        .count(low_cnt)
    );

    // Short run-length for the falling-edge filter
    swss_lowcnt #(.W(FILT_W)) u_filt (
        .clk(clk),
        .reset_n(reset_n),
        .cond(line_low),
        .count(filt_cnt)
    );

    wire logic [CNT_W-1:0] t_pdh = fast_r ? CNT_W'(OD_PDH_CYC) : CNT_W'(STD_PDH_CYC);
    wire logic [CNT_W-1:0] t_pdl = fast_r ? CNT_W'(OD_PDL_CYC) : CNT_W'(STD_PDL_CYC);
    wire logic [CNT_W-1:0] t_smp = fast_r ? CNT_W'(OD_SAMPLE_CYC) : CNT_W'(STD_SAMPLE_CYC);
    wire logic [CNT_W-1:0] t_hold = fast_r ? CNT_W'(OD_READ_HOLD_CYC) : CNT_W'(STD_READ_HOLD_CYC);
    wire logic [CNT_W-1:0] t_reh = fast_r ? CNT_W'(OD_REH_CYC) : CNT_W'(STD_REH_CYC);

    wire logic edge_ok = fast_r ? line_low : (filt_cnt >= FILT_W'(STD_FILT_CYC));

    // reset length class, decided at release
    wire logic long_rst = low_cnt >= CNT_W'(STD_OD_EXIT_CYC);
    wire logic std_rst = low_cnt >= CNT_W'(STD_RESET_CYC);
    wire logic od_rst = (low_cnt >= CNT_W'(OD_RESET_CYC)) && (low_cnt <= CNT_W'(OD_RESET_MAX_CYC));
    wire logic rst_len = fast_r ? (od_rst || long_rst) : std_rst;
    // Reset recognised at the rising edge that ends the low
    wire logic rst_end = rst_len && !line_low && (state_r != ST_PDL);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        fast_nxt = fast_r;
        tmr_nxt = tmr_r + 1'b1;
        drive_nxt = drive_r;
        rx_valid_nxt = 1'b0;
        rx_data_nxt = rx_data_r;
        rst_pulse_nxt = 1'b0;
        pres_done_nxt = 1'b0;
        slot_pulse_nxt = 1'b0;
        if (fast_speed_set) begin
            fast_nxt = 1'b1;
        end
        if (rst_end) begin
            state_nxt = ST_PDH;
            tmr_nxt = '0;
            drive_nxt = 1'b0;
            rst_pulse_nxt = 1'b1;
            // long reset back to standard speed; a set landing together wins
            if (long_rst && !fast_speed_set) begin
                fast_nxt = 1'b0;
            end
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // accepted falling edge starts slot timer
                    if (edge_ok) begin
                        state_nxt = ST_SLOT;
                        tmr_nxt = '0;
                        slot_pulse_nxt = 1'b1;
                        drive_nxt = !tx_bit;
                    end
                end
                ST_SLOT: begin
                    if (tmr_r == t_smp) begin
                        rx_valid_nxt = 1'b1;
                        // Line level; a read zero reports zero
                        rx_data_nxt = !line_low && bit_r;
                    end
                    if (tmr_r >= t_hold) begin
                        drive_nxt = 1'b0;
                    end
                    if ((tmr_r >= t_smp) && (tmr_r >= t_hold)) begin
                        state_nxt = ST_WAITH;
                    end
                end
                ST_WAITH: begin
                    // recovery hold-off starts at line high
                    if (!line_low) begin
                        state_nxt = ST_REH;
                        tmr_nxt = '0;
                    end
                end
                ST_REH: begin
                    if (tmr_r >= t_reh) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_PDH: begin
                    if (tmr_r >= t_pdh) begin
                        state_nxt = ST_PDL;
                        tmr_nxt = '0;
                        drive_nxt = 1'b1;
                    end
                end
                ST_PDL: begin
                    // ends into recovery, then ready for slots
                    if (tmr_r >= t_pdl) begin
                        drive_nxt = 1'b0;
                        state_nxt = ST_WAITH;
                        pres_done_nxt = 1'b1;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    drive_nxt = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // State registers
    // ************************************************************
    // standard speed after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_WAITH;
            fast_r <= 1'b0;
            tmr_r <= '0;
            drive_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fast_r <= fast_nxt;
            tmr_r <= (tmr_r == '1 && tmr_nxt == '0 && state_nxt == state_r) ? tmr_r : tmr_nxt;
            drive_r <= drive_nxt;
        end
    end

    // Bit latched at slot start so a late change cannot corrupt it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_r <= 1'b1;
        end else if (state_r == ST_IDLE && edge_ok) begin
            bit_r <= tx_bit;
        end
    end

    // Event outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_valid_r <= 1'b0;
            rx_data_r <= 1'b0;
            rst_pulse_r <= 1'b0;
            pres_done_r <= 1'b0;
            slot_pulse_r <= 1'b0;
        end else begin
            rx_valid_r <= rx_valid_nxt;
            rx_data_r <= rx_data_nxt;
            rst_pulse_r <= rst_pulse_nxt;
            pres_done_r <= pres_done_nxt;
            slot_pulse_r <= slot_pulse_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign line_out = 1'b0;         // Open drain only ever pulls low
    assign line_oe = drive_r;
    assign fast_speed_flag = fast_r;
    assign rx = '{valid: rx_valid_r, data: rx_data_r};
    assign evt = '{reset_seen: rst_pulse_r, presence_done: pres_done_r, slot_start: slot_pulse_r};

endmodule // swss_core

// [include/swss_pkg.sv]
// Purpose: Constants and carrier types for the single-wire slave signaling engine
// Assumes: 40 MHz clock; line input is asynchronous and synchronised in the core
// Notes: Timing figures are slave-side choices inside the documented windows
package swss_pkg;

    // ************************************************************
    // Clock and timing figures
    // ************************************************************
    localparam int CLK_MHZ = 40;
    // Times in nanoseconds
    localparam int STD_RESET_NS = 480000;     // Shortest standard reset low
    localparam int STD_OD_EXIT_NS = 690000;   // Long reset leaving overdrive
    localparam int OD_RESET_NS = 48000;       // Shortest overdrive reset low
    localparam int OD_RESET_MAX_NS = 80000;   // Longest overdrive reset kept in overdrive
    localparam int STD_PDH_NS = 30000;        // presence_delay standard
    localparam int OD_PDH_NS = 3000;
    localparam int STD_PDL_NS = 120000;       // presence_low_time standard
    localparam int OD_PDL_NS = 12000;
    localparam int STD_SAMPLE_NS = 30000;     // Write sampling point in slot
    localparam int OD_SAMPLE_NS = 3000;
    localparam int STD_READ_HOLD_NS = 30000;  // Read-zero pulldown length
    localparam int OD_READ_HOLD_NS = 3000;
    localparam int STD_FILT_NS = 1000;        // Extra falling-edge filter
    localparam int STD_REH_NS = 5000;         // rising_edge_holdoff standard
    localparam int OD_REH_NS = 2000;
    localparam int CLK_NS = 1000 / CLK_MHZ;

    // Cycle counts: least times round up, longest round down
    localparam int STD_RESET_CYC = (STD_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int STD_OD_EXIT_CYC = (STD_OD_EXIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OD_RESET_CYC = (OD_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int OD_RESET_MAX_CYC = OD_RESET_MAX_NS / CLK_NS;
    localparam int STD_PDH_CYC = (STD_PDH_NS + CLK_NS - 1) / CLK_NS;
    localparam int OD_PDH_CYC = (OD_PDH_NS + CLK_NS - 1) / CLK_NS;
    localparam int STD_PDL_CYC = (STD_PDL_NS + CLK_NS - 1) / CLK_NS;
    localparam int OD_PDL_CYC = (OD_PDL_NS + CLK_NS - 1) / CLK_NS;
    localparam int STD_SAMPLE_CYC = STD_SAMPLE_NS / CLK_NS;
    localparam int OD_SAMPLE_CYC = OD_SAMPLE_NS / CLK_NS;
    localparam int STD_READ_HOLD_CYC = STD_READ_HOLD_NS / CLK_NS;
    localparam int OD_READ_HOLD_CYC = OD_READ_HOLD_NS / CLK_NS;
    localparam int STD_FILT_CYC = (STD_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int STD_REH_CYC = (STD_REH_NS + CLK_NS - 1) / CLK_NS;
    localparam int OD_REH_CYC = (OD_REH_NS + CLK_NS - 1) / CLK_NS;

    localparam int CNT_W = 16;
    localparam int FILT_W = 6;

    // ************************************************************
    // Carrier types
    // ************************************************************
    // Received bit toward the command layer
    typedef struct packed {
        logic valid;   // One-cycle pulse
        logic data;
    } swss_rx_t;

    // Line events toward the command layer
    typedef struct packed {
        logic reset_seen;    // One-cycle pulse on reset detection
        logic presence_done; // One-cycle pulse at end of presence pulse, before recovery hold-off
        logic slot_start;    // One-cycle pulse at accepted falling edge
    } swss_evt_t;

endpackage

// [hw/swss_lowcnt.sv]
// Purpose: Counts consecutive cycles of a condition, saturating
// Assumes: Single clock domain
// Notes: Used for line-low length and glitch filter
`timescale 1ns/1ps
module swss_lowcnt #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Condition and count
    input wire logic cond,
    output logic [W-1:0] count
);

    // ************************************************************
    // Saturating run-length counter
    // ************************************************************
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    wire logic at_max = &count_r;

    // Hold at max so very long lows never wrap into short ones
    assign count_nxt = !cond ? '0 : (at_max ? count_r : count_r + 1'b1);
    assign count = count_r;

    // Counter register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule // swss_lowcnt

// [verification/swss_checker.sv]
// Purpose: Port-level timing checks for the single-wire slave engine
// Assumes: line_in is raw; the core sees it two cycles late
// Notes: Run counters on the raw line give the lengths compared below
`timescale 1ns/1ps
module swss_checker
    import swss_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Line side
    input wire logic line_in,
    input wire logic line_out,
    input wire logic line_oe,
    // Command side
    input wire logic tx_bit,
    input wire logic fast_speed_set,
    input wire swss_rx_t rx,
    input wire swss_evt_t evt,
    input wire logic fast_speed_flag
);
    // ************************************************************
    // Run-length helpers
    // ************************************************************
    logic [CNT_W-1:0] low_r, high_r, last_low_r, last_high_r, fall_r, oe_r, pres_wait_r;

    // Runs are kept at each raw edge, so the sync delay does not matter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_r <= '0;
            high_r <= '0;
            last_low_r <= '0;
            last_high_r <= '0;
            fall_r <= '0;
            oe_r <= '0;
            pres_wait_r <= '0;
        end else begin
            low_r <= line_in ? '0 : low_r + 1'b1;
            high_r <= line_in ? high_r + 1'b1 : '0;
            last_low_r <= (line_in && low_r != '0) ? low_r : last_low_r;
            last_high_r <= (!line_in && high_r != '0) ? high_r : last_high_r;
            fall_r <= (!line_in && high_r != '0) ? '0 : fall_r + 1'b1;
            oe_r <= line_oe ? oe_r + 1'b1 : '0;
            // Cycles from reset seen to presence drive; zero when not waiting
            pres_wait_r <= evt.reset_seen ? 16'd1 : ((pres_wait_r != '0 && !line_oe) ? pres_wait_r + 1'b1 : '0);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ************************************************************
    // Assertions
    // ************************************************************
    a_drain_only: assert property (line_out == 1'b0)
        else $error("line_out driven high");
    a_flag_sets: assert property (fast_speed_set |-> ##[1:2] fast_speed_flag)
        else $error("speed flag not set");
    a_flag_clear: assert property ($fell(fast_speed_flag) |-> last_low_r >= 16'd27600)
        else $error("speed flag cleared by short low");
    a_reset_len: assert property (evt.reset_seen |-> last_low_r >= 16'd1920)
        else $error("reset seen after short low");
    a_pres_start: assert property (evt.reset_seen |-> !line_oe [*8])
        else $error("presence started too early");
    a_pres_delay: assert property ($rose(line_oe) && pres_wait_r != '0 |-> pres_wait_r inside {[116:126], [1196:1206]})
        else $error("presence delay wrong");
    a_pres_late: assert property (pres_wait_r < 16'd1300)
        else $error("presence not started");
    a_oe_length: assert property ($fell(line_oe) |-> oe_r inside {[4798:4802], [478:482], [1196:1202], [116:122]})
        else $error("pulldown length wrong");
    a_holdoff_gap: assert property (evt.slot_start |-> last_high_r >= (fast_speed_flag ? 16'd80 : 16'd200))
        else $error("slot accepted inside hold-off");
    a_std_filter: assert property (evt.slot_start && !fast_speed_flag |-> low_r >= 16'd40)
        else $error("standard filter too short");
    a_sample_point: assert property (rx.valid |-> fall_r inside {[1190:1270], [110:135]})
        else $error("bit sampled at wrong time");
    a_one_bit: assert property (rx.valid |=> !rx.valid)
        else $error("more than one bit per slot");
    a_read_one: assert property (evt.slot_start && tx_bit |-> !line_oe [*8])
        else $error("line pulled for a one");
    a_read_zero: assert property (evt.slot_start && !tx_bit |-> ##[0:2] line_oe)
        else $error("line not pulled for a zero");
endmodule // swss_checker

bind swss_core swss_checker swss_checker_inst (.clk(clk), .reset_n(reset_n), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .tx_bit(tx_bit), .fast_speed_set(fast_speed_set),
    .rx(rx), .evt(evt), .fast_speed_flag(fast_speed_flag));

// [verification/swss_master_model.sv]
// Purpose: Bus master stand-in that pulls the shared line
// Assumes: Line has a pull-up; released means high
// Notes: One task covers resets, write and read slots
`timescale 1ns/1ps
module swss_master_model (
    // Clock
    input wire logic clk,
    // Line level and pulldown
    input wire logic line,
    output logic pull
);
    initial pull = 1'b0;

    // pull, release, sample, wait out slot
    task automatic slot(input int low_c, input int samp_c, input int total_c, output logic seen);
        int i;
        for (i = 0; i < total_c; i++) begin
            @(negedge clk);
            pull = (i < low_c);
            if (i == samp_c) seen = line;
        end
    endtask
endmodule // swss_master_model

// [verification/tb_single_wire_slave_signaling.sv]
// Purpose: Self-checking bench for the slave signaling engine
// Assumes: Pull-up line shared by master model and core
// Notes: Received bits are checked against a queue of expected bits
`timescale 1ns/1ps
module tb_single_wire_slave_signaling;
    import swss_pkg::*;
    logic clk, reset_n, tx_bit, fast_speed_set, pull, line_out, line_oe, fast_speed_flag, seen, rx_on;
    swss_rx_t rx;
    swss_evt_t evt;
    int fail_count, check_count, cyc, n_slot, n_rst, n_pres, s0, i;
    logic exp_q[$];
    // Wired-AND line, high when nobody pulls
    wire logic line = !(pull || line_oe);

    swss_core swss_core_inst (.clk(clk), .reset_n(reset_n), .line_in(line), .line_out(line_out),
        .line_oe(line_oe), .tx_bit(tx_bit), .fast_speed_set(fast_speed_set), .rx(rx), .evt(evt),
        .fast_speed_flag(fast_speed_flag));
    swss_master_model swss_master_model_inst (.clk(clk), .line(line), .pull(pull));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Event tally, bit model and hang guard
    always @(posedge clk) begin
        cyc++;
        if (evt.slot_start === 1'b1) n_slot++;
        if (evt.reset_seen === 1'b1) n_rst++;
        if (evt.presence_done === 1'b1) n_pres++;
        if (rx_on && rx.valid === 1'b1) chk("rx.data", (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx, rx.data);
        if (cyc == 95000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Write slot; a one is released early at a random time
    task automatic wr(input logic v, input logic od);
        tx_bit = 1'b1;
        exp_q.push_back(v);
        if (od) swss_master_model_inst.slot(v ? 30 + int'($urandom % 60) : 320, 0, 520, seen);
        else swss_master_model_inst.slot(v ? 60 + int'($urandom % 600) : 1300 + int'($urandom % 100), 0, 1700, seen);
    endtask

    // Read slot with a random bit offered by the command side
    task automatic rd(input logic od);
        tx_bit = 1'($urandom % 2);
        exp_q.push_back(tx_bit);
        swss_master_model_inst.slot(od ? 20 : 80, od ? 60 : 600, od ? 400 : 1500, seen);
        chk("read line", {15'h0, tx_bit}, {15'h0, seen});
    endtask

    // Bus reset; bit results inside the long low are not modelled
    task automatic rst(input int low_c, input int samp_c, input int high_c);
        tx_bit = 1'b1;
        rx_on = 1'b0;
        swss_master_model_inst.slot(low_c, low_c + samp_c, low_c + high_c, seen);
        rx_on = 1'b1;
        chk("presence", 16'h0, {15'h0, seen});
    endtask

    initial begin
        reset_n = 1'b0;
        tx_bit = 1'b1;
        fast_speed_set = 1'b0;
        rx_on = 1'b0;
        void'($urandom(13));
        repeat (2) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        repeat (400) @(negedge clk);
        rst(19400, 2400, 6400);
        chk("speed at start", 16'h0, {15'h0, fast_speed_flag});
        s0 = n_slot;
        for (i = 0; i < 4; i++) wr(1'($urandom % 2), 1'b0);
        for (i = 0; i < 4; i++) rd(1'b0);
        // Short low that the standard filter must reject
        swss_master_model_inst.slot(20, 0, 400, seen);
        chk("slots std", 16'(s0 + 8), 16'(n_slot));
        @(negedge clk) fast_speed_set = 1'b1;
        @(negedge clk) fast_speed_set = 1'b0;
        @(negedge clk);
        chk("speed set", 16'h1, {15'h0, fast_speed_flag});
        rst(2400, 300, 1920);
        chk("speed kept", 16'h1, {15'h0, fast_speed_flag});
        s0 = n_slot;
        for (i = 0; i < 4; i++) wr(1'($urandom % 2), 1'b1);
        for (i = 0; i < 4; i++) rd(1'b1);
        // Glitch 10 cycles into hold-off is dropped, a later low is a slot
        exp_q.push_back(1'b0);
        swss_master_model_inst.slot(320, 0, 330, seen);
        swss_master_model_inst.slot(20, 0, 400, seen);
        wr(1'b1, 1'b1);
        chk("slots od", 16'(s0 + 10), 16'(n_slot));
        rst(27800, 2400, 6400);
        chk("speed cleared", 16'h0, {15'h0, fast_speed_flag});
        chk("resets", 16'd3, 16'(n_rst));
        chk("presences", 16'd3, 16'(n_pres));
        report_and_stop();
    end
endmodule // tb_single_wire_slave_signaling
